// ---- design/lps_pkg.sv ----
// Package for the ten-port LED driver shutdown and wakeup block.
// Assumes the user imports it whole into the design module header.
package lps_pkg;

  localparam int LPS_PORTS = 10;
  localparam int LPS_FRAME_BITS = 16;
  localparam int LPS_WAKE_PERIODS = 256;

  // Output codes
  localparam logic [7:0] LPS_CODE_LOW = 8'h00;
  localparam logic [7:0] LPS_CODE_RELEASE = 8'h01;
  localparam logic [7:0] LPS_CODE_STATIC = 8'h02;
  localparam logic [7:0] LPS_CODE_PWM_MIN = 8'h03;
  localparam logic [7:0] LPS_CODE_PWM_MAX = 8'hfe;
  localparam logic [7:0] LPS_CODE_OFF = 8'hff;
  localparam logic [7:0] LPS_CODE_RESET = 8'hff;

  // Configuration register layout and reset value
  localparam int LPS_CFG_RUN_POS = 0;
  localparam int LPS_CFG_WAKE_POS = 1;
  localparam int LPS_CFG_EXT_CLK_POS = 2;
  localparam logic [7:0] LPS_CFG_RESET = 8'h00;

  // Command addresses
  localparam logic [6:0] LPS_ADDR_PORT_LAST = 7'h09;
  localparam logic [6:0] LPS_ADDR_ALL = 7'h0a;
  localparam logic [6:0] LPS_ADDR_GRP_LO = 7'h0b;
  localparam logic [6:0] LPS_ADDR_GRP_MID = 7'h0c;
  localparam logic [6:0] LPS_ADDR_GRP_HI = 7'h0d;
  localparam logic [6:0] LPS_ADDR_IN_LO = 7'h0e;
  localparam logic [6:0] LPS_ADDR_IN_HI = 7'h0f;
  localparam logic [6:0] LPS_ADDR_CONFIG = 7'h10;

  typedef struct packed {
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } lps_frame_t;

  typedef struct packed {
    logic pull_low;
    logic sink_on;
    logic mirror_on;
  } lps_drive_t;

endpackage

// ---- design/lps_port_ctrl.sv ----
// Port drive, shutdown, serial command latch and select-line wakeup.
// Assumes a serial master on i_sclk/i_cs_n/i_din, a free-running internal
// PWM oscillator on i_osc_int and board pins resolved outside.
`timescale 1ns/1ps

module lps_port_ctrl
  import lps_pkg::*;
#(
  parameter int N_PORTS = LPS_PORTS,
  parameter int WAKE_COUNT = LPS_WAKE_PERIODS,
  parameter bit EXT_CLK_DEFAULT = 1'b0
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic i_osc_int,
  input wire logic i_serial_out_or_pwm_clock_pin,
  output logic o_serial_out_or_pwm_clock_pin,
  output logic o_serial_out_or_pwm_clock_oe,
  input wire logic [N_PORTS-1:0] i_port_pins,
  output logic [N_PORTS-1:0] o_port_pins,
  output logic [N_PORTS-1:0] o_port_pins_oe,
  output logic [N_PORTS-1:0] o_sink_en,
  output logic [N_PORTS-1:0] o_mirror_en,
  output logic o_run_bit,
  output logic o_pwm_active
);

  if (N_PORTS != LPS_PORTS)
  begin : g_bad_ports
    $error("lps_port_ctrl: port count fixed by the address map");
  end
  if (WAKE_COUNT < 2 || WAKE_COUNT > 511)
  begin : g_bad_wake
    $error("lps_port_ctrl: wake count must be 2..511");
  end

  // ---------------- Serial link domain ----------------
  logic [LPS_FRAME_BITS-1:0] shift_reg;
  logic [LPS_FRAME_BITS-1:0] shift_next;
  logic first_reg;
  logic first_next;
  logic dout_reg;
  logic dout_next;
  logic [LPS_FRAME_BITS-1:0] read_word_reg;

  // First edge of a frame loads the readback word under the shift
  always_comb
  begin
    first_next = 1'b0;
    if (first_reg)
      shift_next = {read_word_reg[LPS_FRAME_BITS-2:0], i_din};
    else
      shift_next = {shift_reg[LPS_FRAME_BITS-2:0], i_din};
    dout_next = first_reg ? read_word_reg[LPS_FRAME_BITS-1] : shift_reg[LPS_FRAME_BITS-1];
  end

  // Frame-start flag held set while select is high
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      first_reg <= 1'b1;
    else
      first_reg <= first_next;
  end

  always_ff @(posedge i_sclk or negedge i_nrst)
  begin
    if (!i_nrst)
      shift_reg <= '0;
    else
      shift_reg <= shift_next;
  end

  always_ff @(negedge i_sclk or negedge i_nrst)
  begin
    if (!i_nrst)
      dout_reg <= 1'b0;
    else
      dout_reg <= dout_next;
  end

  assign o_serial_out_or_pwm_clock_pin = dout_reg;

  // ---------------- Synchronisers ----------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_prev_reg;
  logic osc_s1_reg;
  logic osc_s2_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic pclk_prev_reg;
  logic [N_PORTS-1:0] pin_s1_reg;
  logic [N_PORTS-1:0] pin_s2_reg;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end
    else if (i_ce)
    begin
      cs_s1_reg <= i_cs_n;
      cs_s2_reg <= cs_s1_reg;
      osc_s1_reg <= i_osc_int;
      osc_s2_reg <= osc_s1_reg;
      ext_s1_reg <= i_serial_out_or_pwm_clock_pin;
      ext_s2_reg <= ext_s1_reg;
      pin_s1_reg <= i_port_pins;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ---------------- Control registers ----------------
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] code_reg [N_PORTS];
  logic [7:0] code_next [N_PORTS];
  logic [LPS_FRAME_BITS-1:0] read_word_next;
  logic [7:0] rdata;
  logic cmd_apply;
  logic wake_fire;
  logic run;
  lps_frame_t frame;

  // Shift register is static while select is high
  assign frame = lps_frame_t'(shift_reg);
  assign cmd_apply = cs_s2_reg && !cs_prev_reg;
  assign run = cfg_reg[LPS_CFG_RUN_POS];

  always_comb
  begin
    rdata = 8'h00;
    if (frame.addr <= LPS_ADDR_PORT_LAST)
      rdata = code_reg[frame.addr[3:0]];
    else if (frame.addr == LPS_ADDR_ALL || frame.addr == LPS_ADDR_GRP_LO)
      rdata = code_reg[0];
    else if (frame.addr == LPS_ADDR_GRP_MID)
      rdata = code_reg[4];
    else if (frame.addr == LPS_ADDR_GRP_HI)
      rdata = code_reg[8];
    else if (frame.addr == LPS_ADDR_IN_LO)
      rdata = pin_s2_reg[7:0];
    else if (frame.addr == LPS_ADDR_IN_HI)
      rdata = {6'h00, pin_s2_reg[9:8]};
    else if (frame.addr == LPS_ADDR_CONFIG)
      rdata = cfg_reg;
  end

  // Wakeup first, then the serial command, so a command clearing run wins
  always_comb
  begin
    cfg_next = cfg_reg;
    read_word_next = read_word_reg;
    for (int i = 0; i < N_PORTS; i++)
      code_next[i] = code_reg[i];
    if (wake_fire)
      cfg_next[LPS_CFG_RUN_POS] = 1'b1;
    if (cmd_apply)
    begin
      read_word_next = {frame.rd, frame.addr, rdata};
      if (!frame.rd)
      begin
        if (frame.addr == LPS_ADDR_CONFIG)
          cfg_next = frame.data;
        for (int i = 0; i < N_PORTS; i++)
        begin
          if (frame.addr == 7'(i) || frame.addr == LPS_ADDR_ALL
              || (frame.addr == LPS_ADDR_GRP_LO && i < 4)
              || (frame.addr == LPS_ADDR_GRP_MID && i >= 4 && i < 8)
              || (frame.addr == LPS_ADDR_GRP_HI && i >= 8))
            code_next[i] = frame.data;
        end
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_reg <= LPS_CFG_RESET;
      read_word_reg <= '0;
      cs_prev_reg <= 1'b1;
      for (int i = 0; i < N_PORTS; i++)
        code_reg[i] <= LPS_CODE_RESET;
    end
    else if (i_ce)
    begin
      cfg_reg <= cfg_next;
      read_word_reg <= read_word_next;
      cs_prev_reg <= cs_s2_reg;
      for (int i = 0; i < N_PORTS; i++)
        code_reg[i] <= code_next[i];
    end
  end

  // Strap the pin direction default once, after reset release
  logic strap_done_reg;
  logic ext_sel_reg;
  logic ext_sel_next;
  logic dout_oe_reg;

  always_comb
  begin
    ext_sel_next = strap_done_reg ? cfg_reg[LPS_CFG_EXT_CLK_POS] ^ EXT_CLK_DEFAULT : ext_sel_reg;
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      strap_done_reg <= 1'b0;
      ext_sel_reg <= 1'b0;
      dout_oe_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      strap_done_reg <= 1'b1;
      ext_sel_reg <= ext_sel_next;
      dout_oe_reg <= !ext_sel_next;
    end
  end

  assign o_serial_out_or_pwm_clock_oe = dout_oe_reg;

  // ---------------- PWM clock, counter and wakeup ----------------
  logic pclk;
  logic pwm_edge;
  logic [N_PORTS-1:0] is_pwm;
  logic any_pwm;
  logic [7:0] pwm_cnt_reg;
  logic [7:0] pwm_cnt_next;
  logic [8:0] wake_cnt_reg;
  logic [8:0] wake_cnt_next;
  logic fired_reg;
  logic fired_next;

  assign pclk = ext_sel_reg ? ext_s2_reg : osc_s2_reg;
  assign pwm_edge = pclk && !pclk_prev_reg;
  assign any_pwm = |is_pwm;

  always_comb
  begin
    pwm_cnt_next = pwm_cnt_reg;
    if (!any_pwm)
      pwm_cnt_next = 8'h00;
    else if (pwm_edge)
      pwm_cnt_next = pwm_cnt_reg + 8'h01;
  end

  // Wakeup counter sees select, the wake enable bit and PWM clock only
  always_comb
  begin
    wake_cnt_next = wake_cnt_reg;
    fired_next = fired_reg;
    wake_fire = 1'b0;
    if (cs_s2_reg)
    begin
      wake_cnt_next = 9'h000;
      fired_next = 1'b0;
    end
    else if (cfg_reg[LPS_CFG_WAKE_POS] && pwm_edge && !fired_reg)
    begin
      wake_cnt_next = wake_cnt_reg + 9'h001;
      if (wake_cnt_reg == 9'(WAKE_COUNT - 1))
      begin
        wake_fire = 1'b1;
        fired_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pclk_prev_reg <= 1'b0;
      pwm_cnt_reg <= 8'h00;
      wake_cnt_reg <= 9'h000;
      fired_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      pclk_prev_reg <= pclk;
      pwm_cnt_reg <= pwm_cnt_next;
      wake_cnt_reg <= wake_cnt_next;
      fired_reg <= fired_next;
    end
  end

  // ---------------- Per-port drive ----------------
  lps_drive_t drive_reg [N_PORTS];
  lps_drive_t drive_next [N_PORTS];
  logic run_out_reg;
  logic pwm_active_reg;

  genvar g;
  generate
    for (g = 0; g < N_PORTS; g++)
    begin : g_port
      logic level_reg;
      logic level_next;

      assign is_pwm[g] = code_reg[g] >= LPS_CODE_PWM_MIN && code_reg[g] <= LPS_CODE_PWM_MAX;

      always_comb
      begin
        drive_next[g].pull_low = code_reg[g] == LPS_CODE_LOW;
        drive_next[g].sink_on = run && ((code_reg[g] == LPS_CODE_STATIC)
          || (is_pwm[g] && pwm_cnt_reg < code_reg[g]));
        drive_next[g].mirror_on = drive_next[g].sink_on;
        level_next = code_reg[g] != LPS_CODE_LOW;
      end

      always_ff @(posedge i_clock or negedge i_nrst)
      begin
        if (!i_nrst)
        begin
          drive_reg[g] <= '0;
          level_reg <= 1'b0;
        end
        else if (i_ce)
        begin
          drive_reg[g] <= drive_next[g];
          level_reg <= level_next;
        end
      end

      assign o_port_pins_oe[g] = drive_reg[g].pull_low;
      assign o_port_pins[g] = level_reg;
      assign o_sink_en[g] = drive_reg[g].sink_on;
      assign o_mirror_en[g] = drive_reg[g].mirror_on;

      a_low_code_drive: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && code_reg[g] == LPS_CODE_LOW |=> o_port_pins_oe[g] && !o_sink_en[g])
        else $error("logic low code not driven low");
      a_release_code: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && code_reg[g] != LPS_CODE_LOW |=> !o_port_pins_oe[g])
        else $error("port driven low without low code");
      a_static_sink: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && run && code_reg[g] == LPS_CODE_STATIC |=> o_sink_en[g])
        else $error("static sink not on while running");
      a_shutdown_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && (!run || code_reg[g] == LPS_CODE_OFF) |=> !o_sink_en[g])
        else $error("sink on in shutdown or off code");
      a_mirror_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && is_pwm[g] && pwm_cnt_reg >= code_reg[g] |=> !o_mirror_en[g])
        else $error("mirror on outside pulse on-time");
      a_pwm_duty: assert property (@(posedge i_clock) disable iff (!i_nrst)
        i_ce && run && is_pwm[g] && pwm_cnt_reg < code_reg[g] |=> o_sink_en[g])
        else $error("pulse sink off during on-time");
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      run_out_reg <= 1'b0;
      pwm_active_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      run_out_reg <= cfg_next[LPS_CFG_RUN_POS];
      pwm_active_reg <= any_pwm;
    end
  end

  assign o_run_bit = run_out_reg;
  assign o_pwm_active = pwm_active_reg;

  // ---------------- Assertions ----------------
  sequence s_frame_write_cfg;
    i_ce && cmd_apply && !frame.rd && frame.addr == LPS_ADDR_CONFIG;
  endsequence

  sequence s_wake_alone;
    i_ce && wake_fire && !cmd_apply;
  endsequence

  a_pwm_idle: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_ce && !any_pwm |=> pwm_cnt_reg == 8'h00)
    else $error("PWM counter moving with no pulse code");
  a_cfg_write: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_frame_write_cfg |=> cfg_reg == $past(frame.data))
    else $error("configuration write not applied");
  a_wake_sets_run: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_wake_alone |=> run ##1 o_run_bit)
    else $error("wakeup did not set run");
  a_wake_count: assert property (@(posedge i_clock) disable iff (!i_nrst)
    wake_fire |-> wake_cnt_reg == 9'(WAKE_COUNT - 1) && !cs_s2_reg && pwm_edge)
    else $error("wakeup fired before full count");
  a_wake_disabled: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !cfg_reg[LPS_CFG_WAKE_POS] |-> !wake_fire)
    else $error("wakeup fired while disabled");
  a_cs_high_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_ce && cs_s2_reg |=> wake_cnt_reg == 9'h000 && !fired_reg)
    else $error("wakeup counter not cleared");
  a_fire_once: assert property (@(posedge i_clock) disable iff (!i_nrst)
    wake_fire && i_ce |=> !wake_fire)
    else $error("wakeup fired twice in one pulse");

endmodule

// ---- tb/lps_host_model.sv ----
// Serial host model driving select, serial clock and data in frames.
// Assumes the device shifts in on rising clock and out on falling clock.
`timescale 1ns/1ps

module lps_host_model
(
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  input wire logic i_dout
);
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b1;
  end

  // Clock stands still outside frames; half is the clock high time in ns, the low time is 1.5 times that
  task automatic frame(input logic [15:0] w, input realtime half, output logic [15:0] got);
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      o_din = w[i];
      #(half);
      o_sclk = 1'b1;
      #(half);
      o_sclk = 1'b0;
      #(half / 2.0);
      got[i] = i_dout;
    end
    #(half);
    o_cs_n = 1'b1;
    o_din = ~w[0];
    // Select high long enough before any next frame
    #200;
  endtask

  // Bare select pulse without clock activity
  task automatic hold(input realtime t);
    o_cs_n = 1'b0;
    #(t);
    o_cs_n = 1'b1;
    #200;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the port drive, shutdown and wakeup block.
// Assumes lps_pkg and lps_port_ctrl are compiled first.
`timescale 1ns/1ps

module tb_top;
  import lps_pkg::*;
  localparam int WAKE = 4;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic i_osc_int = 1'b0;
  logic [2:0] osc_cnt = 3'h0;
  logic [9:0] ext_pins = 10'h3ff;
  logic [9:0] pins_in, port_out, port_oe, sink_en, mirror_en, v;
  logic sclk, cs_n, din, dout, dout_oe, osc_pin, run_bit, pwm_active;
  logic [7:0] cfg_m;
  logic [15:0] word;
  int n_mismatch = 0;
  int tests_run = 0;
  int code_m[10];

  always #20 i_clock = ~i_clock;

  // PWM clock of eight system clocks
  always @(negedge i_clock)
  begin
    osc_cnt <= osc_cnt + 3'h1;
    i_osc_int <= osc_cnt[2];
  end

  assign pins_in = ext_pins & ~(port_oe | sink_en);
  assign osc_pin = dout_oe ? dout : i_osc_int;

  lps_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));

  lps_port_ctrl #(.WAKE_COUNT(WAKE)) DUT (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_ce(i_ce), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .i_osc_int(i_osc_int), .i_serial_out_or_pwm_clock_pin(osc_pin),
    .o_serial_out_or_pwm_clock_pin(dout), .o_serial_out_or_pwm_clock_oe(dout_oe),
    .i_port_pins(pins_in), .o_port_pins(port_out), .o_port_pins_oe(port_oe), .o_sink_en(sink_en),
    .o_mirror_en(mirror_en), .o_run_bit(run_bit), .o_pwm_active(pwm_active));

  task automatic finish_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [9:0] sel(input int lo, input int hi, input bit need_run);
    logic [9:0] m;
    m = '0;
    for (int p = 0; p < 10; p++)
      m[p] = code_m[p] >= lo && code_m[p] <= hi && (cfg_m[0] || !need_run);
    return m;
  endfunction

  task automatic chk_all;
    logic [9:0] pm;
    pm = sel(3, 254, 0);
    check(port_oe, sel(0, 0, 0));
    check(sink_en & ~pm, sel(2, 2, 1));
    check(mirror_en & ~pm, sel(2, 2, 1));
    check(run_bit, cfg_m[0]);
    check(pwm_active, |pm);
    check(port_out, {6'h00, ~sel(0, 0, 0)});
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({1'b0, a, d}, 7.5, word);
    repeat (2) @(negedge i_clock);
    if (a <= LPS_ADDR_PORT_LAST)
      code_m[a] = d;
    else if (a == LPS_ADDR_ALL)
      foreach (code_m[p]) code_m[p] = d;
    else if (a == LPS_ADDR_CONFIG)
      cfg_m = d;
  endtask

  // Read result arrives during the following frame, one bit position up
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    host.frame({1'b1, a, 8'h00}, 7.5, word);
    host.frame({1'b1, 7'h7f, 8'h00}, 7.5, word);
    check(word[8:1], e);
  endtask

  task automatic duty(input logic [7:0] c);
    int on = 0;
    int mm = 0;
    wr(7'h03, c);
    repeat (64) @(negedge i_clock);
    repeat (256)
    begin
      repeat (8) @(negedge i_clock);
      on += int'(sink_en[3]);
      if (mirror_en !== sink_en)
        mm++;
    end
    check(16'(on), {8'h00, c});
    check(16'(mm), 16'h0);
  endtask

  // Bare pulse re-latches the last word, so make that word a no-op first
  task automatic wake(input realtime t, input logic e);
    host.frame({1'b0, 7'h7f, 8'h00}, 7.5, word);
    host.hold(t);
    repeat (4) @(negedge i_clock);
    if (e)
      cfg_m[0] = 1'b1;
    check(run_bit, e);
  endtask

  initial
  begin
    repeat (50000) @(posedge i_clock);
    n_mismatch++;
    finish_test();
  end

  initial
  begin
    void'($urandom(43));
    cfg_m = 8'h00;
    foreach (code_m[p]) code_m[p] = 255;
    repeat (10) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clock);
    chk_all();
    check(dout_oe, 16'h1);
    ext_pins = 10'($urandom);
    wr(LPS_ADDR_ALL, 8'h02);
    chk_all();
    wr(7'h00, 8'h00);
    wr(7'h01, 8'h01);
    wr(7'h03, 8'h80);
    wr(7'h09, 8'hff);
    chk_all();
    v = ext_pins & ~sel(0, 0, 0);
    rd(LPS_ADDR_IN_LO, v[7:0]);
    rd(7'h03, 8'h80);
    wr(LPS_ADDR_CONFIG, 8'h01);
    chk_all();
    // Frame sent while clock enable is low is never taken
    i_ce = 1'b0;
    host.frame({1'b0, LPS_ADDR_CONFIG, 8'h00}, 7.5, word);
    @(negedge i_clock);
    i_ce = 1'b1;
    repeat (4) @(negedge i_clock);
    chk_all();
    duty(8'h03);
    duty(8'hfe);
    duty(8'(3 + $urandom % 252));
    wr(LPS_ADDR_CONFIG, 8'h05);
    check(dout_oe, 16'h0);
    duty(8'h40);
    wr(LPS_ADDR_CONFIG, 8'h01);
    check(dout_oe, 16'h1);
    wr(LPS_ADDR_CONFIG, 8'h00);
    chk_all();
    wr(7'h02, 8'h00);
    wr(7'h00, 8'h02);
    chk_all();
    rd(LPS_ADDR_CONFIG, 8'h00);
    rd(7'h00, 8'h02);
    wr(LPS_ADDR_CONFIG, 8'h01);
    chk_all();
    wr(LPS_ADDR_CONFIG, 8'h00);
    wake(2560.0, 1'b0);
    wr(LPS_ADDR_CONFIG, 8'h02);
    wake(600.0, 1'b0);
    wake(2560.0, 1'b1);
    chk_all();
    rd(LPS_ADDR_CONFIG, 8'h03);
    wr(LPS_ADDR_CONFIG, 8'h02);
    chk_all();
    fork
      host.frame({1'b0, LPS_ADDR_CONFIG, 8'h02}, 100.0, word);
      #3000 check(run_bit, 16'h1);
    join
    repeat (2) @(negedge i_clock);
    chk_all();
    rd(7'h7f, 8'h00);
    finish_test();
  end
endmodule
